// ### include/apd_params.svh
// Constants for the automatic power-down and reset controller.
// Assumes one 25 MHz clock; included by bare name.
`ifndef APD_PARAMS_SVH
`define APD_PARAMS_SVH
`define APD_CLK_MHZ           25
`define APD_IDLE_LIMIT        4'hf
`define APD_CNT_W             4
`define APD_REGA_TURBO_OFF    3
`define APD_REGA_AND_CLK_BLK  4
`define APD_REGA_MC_CLK_BLK   5
`define APD_REGB_A30_BLK      0
`define APD_REGB_A74_BLK      2
`define APD_REGB_CTL0_BLK     3
`define APD_REGB_CTL1_BLK     4
`define APD_REGB_CTL2_BLK     5
`define APD_REGB_STRB_BLK     6
`define APD_RECOVERY_NS       120
`define APD_RECOVERY_CYC      (`APD_RECOVERY_NS * `APD_CLK_MHZ / 1000)
`define APD_WARM_RST_NS       150
`define APD_WARM_RST_CYC      ((`APD_WARM_RST_NS * `APD_CLK_MHZ + 999) / 1000)
`define APD_PWRUP_RST_US      1000
`define APD_PWRUP_RST_CYC     (`APD_PWRUP_RST_US * `APD_CLK_MHZ)
`endif

// ### include/apd_pkg.sv
// Types for the automatic power-down and reset controller.
// Assumes apd_params.svh is included alongside.
package apd_pkg;
  typedef enum logic [1:0] {
    APD_ST_RESET    = 2'b00,
    APD_ST_RECOVER  = 2'b01,
    APD_ST_RUN      = 2'b10,
    APD_ST_PWRDN    = 2'b11
  } apd_state_t;
endpackage

// ### design/apd_idle_counter.sv
// Idle counter that watches the address strobe.
// Assumes strobe and clock qualifier synchronous to clk.
`timescale 1ns/1ps
`include "apd_params.svh"
module apd_idle_counter #(
  parameter int CNT_W = `APD_CNT_W
) (
  input  wire logic             clk,        // System clock
  input  wire logic             rst_n,      // Sync reset, low
  input  wire logic             tick,       // Logic clock edge
  input  wire logic             enable,     // Unit enabled
  input  wire logic             strobe,     // Address strobe level
  input  wire logic             polarity,   // Idle strobe level
  output logic                  expired     // Limit reached
);
  if (CNT_W != 4) begin : g_bad_width
    $error("apd_idle_counter supports four-bit count only");
  end
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             strobe_q;
  wire              toggled  = strobe != strobe_q;
  wire              at_idle  = strobe == polarity;
  wire              at_limit = cnt_q == `APD_IDLE_LIMIT;
  always_comb begin
    cnt_d = cnt_q;
    if (!enable || toggled || !at_idle) begin
      cnt_d = '0;
    end else if (tick && !at_limit) begin
      cnt_d = cnt_q + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q    <= '0;
      strobe_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      strobe_q <= strobe;
    end
  end
  assign expired = at_limit && enable && at_idle && !toggled;
endmodule

// ### design/apd_power_ctrl.sv
// Power-down, power gating and reset sequencing top level.
// Assumes all inputs synchronous to clk; reset_in is active high.
`timescale 1ns/1ps
`include "apd_params.svh"
module apd_power_ctrl #(
  parameter int RECOVERY_CYC = `APD_RECOVERY_CYC
) (
  input  wire logic       clk,               // 25 MHz clock
  input  wire logic       rst_n,             // Sync reset, low
  input  wire logic       reset_in,          // Device reset pin, high resets
  input  wire logic       warm,              // Reset is warm, not power-up
  input  wire logic       apd_enable,        // Auto powerdown unit enable
  input  wire logic       strobe_polarity,   // Idle strobe level
  input  wire logic       addr_strobe_in,    // Address strobe
  input  wire logic       logic_clock_in,    // Logic clock
  input  wire logic       chip_select_n,     // Chip select, low active
  input  wire logic       vcc_below_stby,    // Main below standby supply
  input  wire logic [7:0] power_ctrl_reg_a,  // Power control register A
  input  wire logic [7:0] power_ctrl_reg_b,  // Power control register B
  input  wire logic [7:0] addr_lo_in,        // Low address bus
  input  wire logic       ctrl_in_0,         // Control input 0
  input  wire logic       ctrl_in_1,         // Control input 1
  input  wire logic       ctrl_in_2,         // Control input 2
  input  wire logic       byte_enable_in,    // Byte enable
  output logic            powerdown_flag,    // Powerdown active
  output logic            bus_block,         // Bus blocked from memories
  output logic            mem_enable,        // Memories selected
  output logic            mem_standby,       // Memories in standby
  output logic            logic_turbo,       // Logic arrays full speed
  output logic            and_clk_en,        // Clock to AND array
  output logic            mc_clk_en,         // Clock to macrocells
  output logic [7:0]      and_addr,          // Address to AND array
  output logic            and_ctrl_0,        // Control 0 to AND array
  output logic            and_ctrl_1,        // Control 1 to AND array
  output logic            and_ctrl_2,        // Control 2 to AND array
  output logic            and_strobe,        // Strobe to AND array
  output logic            and_byte_en,       // Byte enable to AND array
  output logic            data_port_oe,      // Data/peripheral port drive
  output logic            addr_out_valid,    // Latched address defined
  output logic            battery_on_flag,   // SRAM on battery
  output logic            flash_read_mode,   // Flash in read mode
  output logic            in_reset,          // Device held in reset
  output logic            access_ready       // Memory access allowed
);
  // Recovery count lives in an 8-bit register
  if (RECOVERY_CYC < 1 || RECOVERY_CYC > 255) begin : g_bad_recovery
    $error("apd_power_ctrl needs RECOVERY_CYC from 1 to 255");
  end
  // ==========================================================
  // Edge detection and idle counting
  logic lclk_q;
  logic strobe_q;
  logic expired;
  wire  tick    = logic_clock_in && !lclk_q;
  wire  pulsing = addr_strobe_in != strobe_q;
  apd_idle_counter #(.CNT_W(`APD_CNT_W)) u_idle (
    .clk      (clk),
    .rst_n    (rst_n),
    .tick     (tick),
    .enable   (apd_enable),
    .strobe   (addr_strobe_in),
    .polarity (strobe_polarity),
    .expired  (expired)
  );
  // ==========================================================
  // Reset and powerdown sequencing
  apd_pkg::apd_state_t st_q;
  apd_pkg::apd_state_t st_d;
  logic [7:0]          rcv_q;
  logic [7:0]          rcv_d;
  wire  wake = pulsing || !chip_select_n;
  always_comb begin
    st_d  = st_q;
    rcv_d = rcv_q;
    case (st_q)
      apd_pkg::APD_ST_RESET: begin
        rcv_d = 8'h00;
        if (!reset_in) begin
          st_d = apd_pkg::APD_ST_RECOVER;
        end
      end
      apd_pkg::APD_ST_RECOVER: begin
        rcv_d = rcv_q + 8'h01;
        if (reset_in) begin
          st_d = apd_pkg::APD_ST_RESET;
        end else if (rcv_q >= 8'(RECOVERY_CYC - 1)) begin
          st_d = apd_pkg::APD_ST_RUN;
        end
      end
      apd_pkg::APD_ST_RUN: begin
        if (reset_in) begin
          st_d = apd_pkg::APD_ST_RESET;
        end else if (expired && chip_select_n) begin
          st_d = apd_pkg::APD_ST_PWRDN;
        end
      end
      apd_pkg::APD_ST_PWRDN: begin
        if (reset_in) begin
          st_d = apd_pkg::APD_ST_RESET;
        end else if (wake || !apd_enable) begin
          st_d = apd_pkg::APD_ST_RUN;
        end
      end
      default: st_d = apd_pkg::APD_ST_RESET;
    endcase
  end
  // ==========================================================
  // Output decode
  wire pd_d    = st_d == apd_pkg::APD_ST_PWRDN;
  wire rst_d   = st_d == apd_pkg::APD_ST_RESET || st_d == apd_pkg::APD_ST_RECOVER;
  wire run_d   = st_d == apd_pkg::APD_ST_RUN;
  wire pwrup_d = rst_d && !warm;
  wire memen_d = run_d && !chip_select_n;
  wire turbo_d = !power_ctrl_reg_a[`APD_REGA_TURBO_OFF];
  wire aclk_d  = !power_ctrl_reg_a[`APD_REGA_AND_CLK_BLK];
  wire mclk_d  = !power_ctrl_reg_a[`APD_REGA_MC_CLK_BLK];
  wire a30_ok  = !power_ctrl_reg_b[`APD_REGB_A30_BLK] && !pd_d;
  wire a74_ok  = !power_ctrl_reg_b[`APD_REGB_A74_BLK] && !pd_d;
  wire [7:0] addr_d = {addr_lo_in[7:4] & {4{a74_ok}}, addr_lo_in[3:0] & {4{a30_ok}}};
  wire c0_d  = ctrl_in_0 && !power_ctrl_reg_b[`APD_REGB_CTL0_BLK] && !pd_d;
  wire c1_d  = ctrl_in_1 && !power_ctrl_reg_b[`APD_REGB_CTL1_BLK] && !pd_d;
  wire c2_d  = ctrl_in_2 && !power_ctrl_reg_b[`APD_REGB_CTL2_BLK] && !pd_d;
  wire stb_d = addr_strobe_in && !power_ctrl_reg_b[`APD_REGB_STRB_BLK] && !pd_d;
  wire dbe_d = byte_enable_in && !power_ctrl_reg_b[`APD_REGB_CTL0_BLK] && !pd_d;
  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q     <= apd_pkg::APD_ST_RESET;
      rcv_q    <= 8'h00;
      lclk_q   <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      rcv_q    <= rcv_d;
      lclk_q   <= logic_clock_in;
      strobe_q <= addr_strobe_in;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powerdown_flag  <= 1'b0;
      bus_block       <= 1'b0;
      mem_enable      <= 1'b0;
      mem_standby     <= 1'b1;
      logic_turbo     <= 1'b1;
      and_clk_en      <= 1'b1;
      mc_clk_en       <= 1'b1;
      and_addr        <= 8'h00;
      and_ctrl_0      <= 1'b0;
      and_ctrl_1      <= 1'b0;
      and_ctrl_2      <= 1'b0;
      and_strobe      <= 1'b0;
      and_byte_en     <= 1'b0;
      data_port_oe    <= 1'b0;
      addr_out_valid  <= 1'b0;
      battery_on_flag <= 1'b0;
      flash_read_mode <= 1'b1;
      in_reset        <= 1'b1;
      access_ready    <= 1'b0;
    end else begin
      powerdown_flag  <= pd_d;
      bus_block       <= pd_d;
      mem_enable      <= memen_d;
      mem_standby     <= !memen_d;
      logic_turbo     <= turbo_d;
      and_clk_en      <= aclk_d && !pwrup_d;
      mc_clk_en       <= mclk_d && !pwrup_d;
      and_addr        <= addr_d;
      and_ctrl_0      <= c0_d;
      and_ctrl_1      <= c1_d;
      and_ctrl_2      <= c2_d;
      and_strobe      <= stb_d;
      and_byte_en     <= dbe_d;
      data_port_oe    <= run_d && !chip_select_n;
      addr_out_valid  <= run_d;
      battery_on_flag <= vcc_below_stby;
      flash_read_mode <= pwrup_d ? 1'b1 : flash_read_mode;
      in_reset        <= rst_d;
      access_ready    <= !rst_d;
    end
  end
endmodule

// ### tb/apd_mcu_model.sv
// Microcontroller side: drives the address strobe.
// Assumes the bench clock; idle level set by the bench.
`timescale 1ns/1ps
module apd_mcu_model (
  input  wire logic clk,      // Bench clock
  input  wire logic active,   // Bus busy
  input  wire logic idle_lvl, // Level while asleep
  output logic      strobe    // Address strobe
);
  initial strobe = 1'b0;
  // Pulses while busy, rests at the idle level when asleep
  always @(posedge clk) strobe <= active ? !strobe : idle_lvl;
endmodule

// ### tb/apd_power_ctrl_checker.sv
// Checker on the ports of apd_power_ctrl.
// Assumes a single clock and a synchronous low reset.
`timescale 1ns/1ps
module apd_power_ctrl_checker (
  input wire logic       clk,              // Clock
  input wire logic       rst_n,            // Sync reset, low
  input wire logic       reset_in,         // Device reset pin
  input wire logic       chip_select_n,    // Chip select, low
  input wire logic       apd_enable,       // Unit enable
  input wire logic       vcc_below_stby,   // Supply low
  input wire logic [7:0] power_ctrl_reg_a, // Register A
  input wire logic [7:0] power_ctrl_reg_b, // Register B
  input wire logic [7:0] and_addr,         // Gated address
  input wire logic       powerdown_flag,   // Powerdown
  input wire logic       bus_block,        // Bus blocked
  input wire logic       mem_enable,       // Memories selected
  input wire logic       mem_standby,      // Memories standby
  input wire logic       logic_turbo,      // Turbo
  input wire logic       and_clk_en,       // AND array clock
  input wire logic       mc_clk_en,        // Macrocell clock
  input wire logic       data_port_oe,     // Data port drive
  input wire logic       battery_on_flag,  // Battery flag
  input wire logic       flash_read_mode,  // Flash read mode
  input wire logic       in_reset,         // In reset
  input wire logic       access_ready      // Access allowed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions
  a_turbo_follow: assert property ($past(rst_n) |-> logic_turbo == !$past(power_ctrl_reg_a[3]))
    else $error("turbo output wrong");
  a_clk_gate: assert property ($past(access_ready) && access_ready |->
    and_clk_en == !$past(power_ctrl_reg_a[4]) && mc_clk_en == !$past(power_ctrl_reg_a[5]))
    else $error("logic clock gating wrong");
  a_batt_follow: assert property ($past(rst_n) |-> battery_on_flag == $past(vcc_below_stby))
    else $error("battery flag wrong");
  a_standby_pair: assert property (mem_standby == !mem_enable)
    else $error("standby not inverse of enable");
  a_cs_blocks: assert property ($past(chip_select_n) |-> !mem_enable)
    else $error("memories enabled with select high");
  a_pd_blocks: assert property (powerdown_flag |->
    bus_block && !mem_enable && !data_port_oe && and_addr == 8'h00)
    else $error("bus not blocked in powerdown");
  a_pd_cause: assert property ($rose(powerdown_flag) |->
    $past(chip_select_n) && $past(apd_enable))
    else $error("powerdown without cause");
  a_cs_wake: assert property (powerdown_flag && !chip_select_n |-> ##[1:2] !powerdown_flag)
    else $error("select low did not wake");
  a_ready_state: assert property (access_ready == !in_reset)
    else $error("ready during reset");
  a_reset_enter: assert property (reset_in |-> ##[1:2] in_reset)
    else $error("reset input ignored");
  a_flash_read: assert property (flash_read_mode)
    else $error("flash left read mode");
  a_gate_addr: assert property ($past(power_ctrl_reg_b[0]) && $past(rst_n) |->
    and_addr[3:0] == 4'h0)
    else $error("low address not blocked");
  c_pd_in: cover property ($rose(powerdown_flag));
  c_pd_out: cover property ($fell(powerdown_flag));
  c_ready: cover property ($rose(access_ready));
endmodule

// ### tb/tb.sv
// Testbench for apd_power_ctrl with a strobe model.
// Assumes the checker and model files compile first.
`timescale 1ns/1ps
module tb;
  localparam int REC = 3;
  logic clk = 0, rst_n = 0, reset_in = 1, warm = 0, apd_enable = 0, strobe_polarity = 1;
  logic logic_clock_in = 0, chip_select_n = 1, vcc_below_stby = 0, act = 1, idle = 1;
  logic ctrl_in_0 = 1, ctrl_in_1 = 1, ctrl_in_2 = 1, byte_enable_in = 1, addr_strobe_in;
  logic [7:0] power_ctrl_reg_a = 8'h00, power_ctrl_reg_b = 8'h00, addr_lo_in = 8'hff;
  logic powerdown_flag, bus_block, mem_enable, mem_standby, logic_turbo, and_clk_en;
  logic mc_clk_en, and_ctrl_0, and_ctrl_1, and_ctrl_2, and_strobe, and_byte_en;
  logic data_port_oe, addr_out_valid, battery_on_flag, flash_read_mode, in_reset;
  logic access_ready;
  logic [7:0] and_addr;
  int fails = 0, tests_run = 0, cycles = 0, n;
  always #20 clk = ~clk;
  apd_mcu_model i_apd_mcu_model (.clk, .active(act), .idle_lvl(idle), .strobe(addr_strobe_in));
  apd_power_ctrl #(.RECOVERY_CYC(REC)) i_apd_power_ctrl (.clk, .rst_n, .reset_in, .warm,
    .apd_enable, .strobe_polarity, .addr_strobe_in, .logic_clock_in, .chip_select_n,
    .vcc_below_stby, .power_ctrl_reg_a, .power_ctrl_reg_b, .addr_lo_in, .ctrl_in_0,
    .ctrl_in_1, .ctrl_in_2, .byte_enable_in, .powerdown_flag, .bus_block, .mem_enable,
    .mem_standby, .logic_turbo, .and_clk_en, .mc_clk_en, .and_addr, .and_ctrl_0,
    .and_ctrl_1, .and_ctrl_2, .and_strobe, .and_byte_en, .data_port_oe, .addr_out_valid,
    .battery_on_flag, .flash_read_mode, .in_reset, .access_ready);
  // ==========================================
  // Tasks
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic ticks(int k);
    repeat (k) begin
      logic_clock_in = 1'b1;
      cyc(1);
      logic_clock_in = 1'b0;
      cyc(1);
    end
  endtask
  task automatic enter_pd(logic pol);
    strobe_polarity = pol;
    idle = pol;
    act = 1'b0;
    cyc(2);
    ticks(14);
    cyc(4);
    chk("pd early", 8'h00, {7'h0, powerdown_flag});
    ticks(1);
    cyc(4);
    chk("pd entry", 8'h01, {7'h0, powerdown_flag});
  endtask
  task automatic wait_ready();
    n = 0;
    while (access_ready !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      conclude();
    end
  end
  // ==========================================
  // Sequence
  initial begin
    cyc(8);
    rst_n = 1'b1;
    cyc(25000);
    chk("access_ready", 8'h00, {7'h0, access_ready});
    chk("flash_read_mode", 8'h01, {7'h0, flash_read_mode});
    chk("pwrup clk_en", 8'h00, {7'h0, and_clk_en});
    chk("in_reset", 8'h01, {7'h0, in_reset});
    chk("addr_out_valid", 8'h00, {7'h0, addr_out_valid});
    reset_in = 1'b0;
    wait_ready();
    chk("recovery", 8'(REC + 1), 8'(n));
    apd_enable = 1'b1;
    power_ctrl_reg_a = 8'h30;
    enter_pd(1'b1);
    chk("bus_block", 8'h01, {7'h0, bus_block});
    chk("mem_standby", 8'h01, {7'h0, mem_standby});
    chk("data_port_oe", 8'h00, {7'h0, data_port_oe});
    chk("and_clk_en", 8'h00, {7'h0, and_clk_en});
    chk("logic_turbo", 8'h01, {7'h0, logic_turbo});
    chk("mc_clk_en", 8'h00, {7'h0, mc_clk_en});
    chk("pd and_strobe", 8'h00, {7'h0, and_strobe});
    chk("pd addr valid", 8'h00, {7'h0, addr_out_valid});
    power_ctrl_reg_a = 8'h08;
    cyc(2);
    chk("turbo off", 8'h00, {7'h0, logic_turbo});
    act = 1'b1;
    cyc(3);
    chk("strobe wake", 8'h00, {7'h0, powerdown_flag});
    enter_pd(1'b0);
    chip_select_n = 1'b0;
    cyc(3);
    chk("cs wake", 8'h00, {7'h0, powerdown_flag});
    chk("mem_enable", 8'h01, {7'h0, mem_enable});
    ticks(20);
    chk("cs held", 8'h00, {7'h0, powerdown_flag});
    chip_select_n = 1'b1;
    enter_pd(1'b1);
    reset_in = 1'b1;
    warm = 1'b1;
    cyc(4);
    chk("reset wake", 8'h00, {7'h0, powerdown_flag});
    chk("warm clk_en", 8'h01, {7'h0, and_clk_en});
    reset_in = 1'b0;
    wait_ready();
    chk("warm recovery", 8'(REC + 1), 8'(n));
    apd_enable = 1'b0;
    ticks(20);
    chk("disabled", 8'h00, {7'h0, powerdown_flag});
    chk("and_strobe", 8'h01, {7'h0, and_strobe});
    chk("run addr valid", 8'h01, {7'h0, addr_out_valid});
    chk("run in_reset", 8'h00, {7'h0, in_reset});
    apd_enable = 1'b1;
    idle = 1'b0;
    cyc(2);
    ticks(20);
    chk("wrong level", 8'h00, {7'h0, powerdown_flag});
    idle = 1'b1;
    cyc(2);
    ticks(10);
    act = 1'b1;
    cyc(1);
    act = 1'b0;
    cyc(2);
    ticks(10);
    chk("restart", 8'h00, {7'h0, powerdown_flag});
    ticks(5);
    cyc(4);
    chk("restart entry", 8'h01, {7'h0, powerdown_flag});
    act = 1'b1;
    cyc(3);
    power_ctrl_reg_b = 8'h01;
    cyc(2);
    chk("and_addr", 8'hf0, and_addr);
    power_ctrl_reg_b = 8'h08;
    vcc_below_stby = 1'b1;
    cyc(2);
    chk("and_ctrl_0", 8'h00, {7'h0, and_ctrl_0});
    chk("and_byte_en", 8'h00, {7'h0, and_byte_en});
    chk("and_ctrl_1", 8'h01, {7'h0, and_ctrl_1});
    chk("and_ctrl_2", 8'h01, {7'h0, and_ctrl_2});
    chk("battery_on_flag", 8'h01, {7'h0, battery_on_flag});
    power_ctrl_reg_b = 8'h74;
    vcc_below_stby = 1'b0;
    cyc(2);
    chk("and_addr high", 8'h0f, and_addr);
    chk("ctrl gates", 8'h03, {4'h0, and_ctrl_2, and_ctrl_1, and_ctrl_0, and_byte_en});
    chk("strobe gate", 8'h00, {7'h0, and_strobe});
    chk("battery off", 8'h00, {7'h0, battery_on_flag});
    conclude();
  end
endmodule
bind apd_power_ctrl apd_power_ctrl_checker i_chk (.clk, .rst_n, .reset_in, .chip_select_n,
  .apd_enable, .vcc_below_stby, .power_ctrl_reg_a, .power_ctrl_reg_b, .and_addr,
  .powerdown_flag, .bus_block, .mem_enable, .mem_standby, .logic_turbo, .and_clk_en,
  .mc_clk_en, .data_port_oe, .battery_on_flag, .flash_read_mode, .in_reset, .access_ready);
